/* hdl/black_level_calibration.sv */
// black level calibration: dark line sequencing, per-column filtering, offset correction
// assumes pixels arrive one per cycle with pixInValid, frameStart pulses once per frame
// What this block does
// - emit the programmed 1..255 dark lines at every frame start
// - global shutter dark line is exactly 162 kernels long
// - rolling shutter dark line is the active window's line length
// - skip bit blanks first dark line and keeps it out of calibration
// - auto mode derives offset from filtered dark samples, applies to image
// - dark samples leave raw, never corrected
// - manual mode adds offset magnitude, or subtracts it when sign set
// - manual offset is the same for all columns
// - offset field all ones freezes computed factors in auto mode
// - unfrozen auto mode recomputes factors every frame for the columns with enough samples
// - sign bit ignored while auto mode is on
// - calibrate each of the eight kernel columns separately
// - filter 2^exp samples; in unfrozen auto mode, flag a column lacking enough samples
`timescale 1ns/10ps
`include "black_level_calibration_map.svh"
module black_level_calibration
  import black_level_calibration_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // register port
  input  wire logic [8:0]   regAddr,
  input  wire logic [15:0]  regWrData,
  input  wire logic         regWrEn,
  input  wire logic         regRdEn,
  output logic [15:0]       regRdData,
  // readout mode
  input  wire logic         rollingShutter,
  input  wire logic [9:0]   activeLineKernels,
  // pixel input
  input  wire logic         frameStart,
  input  wire pixel_t       pixIn,
  input  wire logic         pixInValid,
  // pixel output
  output pixel_t            pixOut,
  output logic              pixOutValid,
  output logic              pixOutDark,
  output logic              darkPhase,
  output logic [7:0]        insufficientSampleFlags
);
  logic [15:0] ctrl_reg;
  logic [15:0] darkCfg_reg;
  logic [15:0] filterCfg_reg;
  blc_state_e  state_reg;
  logic [7:0]  linesLatched_reg;
  logic        skipLatched_reg;
  logic [12:0] lineLenPix_reg;
  logic [12:0] pixCnt_reg;
  logic [7:0]  lineCnt_reg;
  logic [2:0]  imgCol_reg;
  offset_t     offs_reg [`KERNEL_COLS];
  pixel_t      colMean [`KERNEL_COLS];
  logic [7:0]  colEnough;

  logic        autoEn;
  logic        frozen;
  logic        inDark;
  logic        inImage;
  logic        endOfLine;
  logic        endOfDark;
  logic        blankLine;
  logic        sampleEn;
  logic [2:0]  darkCol;
  offset_t     manualOfs;
  offset_t     appliedOfs;
  pixel_t      corrected;
  offset_t     newOfs [`KERNEL_COLS];
  logic [7:0]  ofsLoad;
  logic        darkDone_reg;

  assign autoEn    = ctrl_reg[`AUTO_EN_BIT];
  assign frozen    = autoEn && (ctrl_reg[`OFS_MSB:`OFS_LSB] == `OFS_FREEZE);
  assign inDark    = (state_reg == ST_DARK);
  assign inImage   = (state_reg == ST_IMAGE);
  assign endOfLine = inDark && pixInValid && (pixCnt_reg == lineLenPix_reg - 13'h0001);
  assign endOfDark = endOfLine && (lineCnt_reg == linesLatched_reg - 8'h01);
  assign blankLine = skipLatched_reg && (lineCnt_reg == 8'h00);
  assign sampleEn  = inDark && pixInValid && !blankLine;
  assign darkCol   = pixCnt_reg[2:0];
  assign manualOfs = ctrl_reg[`OFS_SIGN_BIT] ? -offset_t'({2'b00, ctrl_reg[`OFS_MSB:`OFS_LSB]})
                                             : offset_t'({2'b00, ctrl_reg[`OFS_MSB:`OFS_LSB]});
  // the pixel right after the dark lines already sees the factor loaded at that edge
  assign appliedOfs = !autoEn ? manualOfs
                    : ofsLoad[imgCol_reg] ? newOfs[imgCol_reg]
                    : offs_reg[imgCol_reg];

  function automatic pixel_t sat_add(input pixel_t p, input offset_t o);
    logic signed [11:0] s;
    s = $signed({2'b00, p}) + 12'(o);
    if (s < 12'sh000)
      sat_add = 10'h000;
    else if (s > $signed({2'b00, `PIX_MAX}))
      sat_add = `PIX_MAX;
    else
      sat_add = s[9:0];
  endfunction : sat_add

  assign corrected = sat_add(pixIn, appliedOfs);

  // register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg      <= `CTRL_RESET;
      darkCfg_reg   <= `DARK_CFG_RESET;
      filterCfg_reg <= `FILTER_CFG_RESET;
    end else if (regWrEn) begin
      if (regAddr == `BLACK_CAL_CTRL_ADDR)
        ctrl_reg <= regWrData;
      if (regAddr == `DARK_LINE_CFG_ADDR)
        darkCfg_reg <= regWrData;
      if (regAddr == `FILTER_CFG_ADDR)
        filterCfg_reg <= regWrData;
    end
  end

  // register reads, unmapped addresses read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 16'h0000;
    end else if (regRdEn) begin
      unique case (regAddr)
        `BLACK_CAL_CTRL_ADDR: regRdData <= ctrl_reg;
        `DARK_LINE_CFG_ADDR:  regRdData <= darkCfg_reg;
        `FILTER_CFG_ADDR:     regRdData <= filterCfg_reg;
        `SAMPLE_ERR_ADDR:     regRdData <= {8'h00, insufficientSampleFlags};
        default:              regRdData <= 16'h0000;
      endcase
    end
  end

  // frame sequencer; dark line config is latched at frame start so mid-frame writes to it cannot tear a frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg        <= ST_IDLE;
      linesLatched_reg <= 8'h01;
      skipLatched_reg  <= 1'b0;
      lineLenPix_reg   <= 13'h0008;
    end else if (frameStart) begin
      state_reg        <= ST_DARK;
      // a zero line count is out of range; one line is produced instead
      linesLatched_reg <= (darkCfg_reg[`LINES_MSB:`LINES_LSB] == 8'h00) ? 8'h01
                          : darkCfg_reg[`LINES_MSB:`LINES_LSB];
      skipLatched_reg  <= darkCfg_reg[`SKIP_FIRST_BIT];
      lineLenPix_reg   <= rollingShutter ? {activeLineKernels, 3'b000}
                                         : {`GS_LINE_KERNELS, 3'b000};
    end else if (endOfDark) begin
      state_reg <= ST_IMAGE;
    end
  end

  // dark line position counters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pixCnt_reg  <= 13'h0000;
      lineCnt_reg <= 8'h00;
    end else if (frameStart) begin
      pixCnt_reg  <= 13'h0000;
      lineCnt_reg <= 8'h00;
    end else if (endOfLine) begin
      pixCnt_reg  <= 13'h0000;
      lineCnt_reg <= lineCnt_reg + 8'h01;
    end else if (inDark && pixInValid) begin
      pixCnt_reg <= pixCnt_reg + 13'h0001;
    end
  end

  // image column tracks the kernel position of regular pixels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      imgCol_reg <= 3'h0;
    else if (frameStart)
      imgCol_reg <= 3'h0;
    else if (inImage && pixInValid)
      imgCol_reg <= imgCol_reg + 3'h1;
  end

  // factors load one edge after the last dark sample, once it sits in its accumulator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      darkDone_reg <= 1'b0;
    else
      darkDone_reg <= endOfDark && !frameStart;
  end

  genvar c;
  generate
    for (c = 0; c < `KERNEL_COLS; c++) begin : g_col
      blc_col_accum u_accum (
        .clk      (clk),
        .nrst     (nrst),
        .clear    (frameStart),
        .sampleEn (sampleEn && (darkCol == 3'(c))),
        .expSel   (filterCfg_reg[`EXP_MSB:`EXP_LSB]),
        .sample   (pixIn),
        .mean     (colMean[c]),
        .enough   (colEnough[c])
      );

      assign newOfs[c]  = offset_t'($signed({1'b0, `BLACK_TARGET})
                                    - $signed({1'b0, colMean[c]}));
      assign ofsLoad[c] = darkDone_reg && autoEn && !frozen && colEnough[c];

      // columns short of samples keep their old factor
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
          offs_reg[c] <= 11'sh000;
        else if (ofsLoad[c])
          offs_reg[c] <= newOfs[c];
      end
    end
  endgenerate

  // shortage flags are refreshed at each auto mode dark phase end; frozen and manual frames keep the last verdict
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      insufficientSampleFlags <= 8'h00;
    else if (darkDone_reg && autoEn && !frozen)
      insufficientSampleFlags <= ~colEnough;
  end

  // pixel output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pixOut      <= 10'h000;
      pixOutValid <= 1'b0;
      pixOutDark  <= 1'b0;
      darkPhase   <= 1'b0;
    end else begin
      darkPhase   <= inDark && !endOfDark && !frameStart;
      pixOutDark  <= inDark;
      pixOutValid <= pixInValid && (inImage || (inDark && !blankLine));
      pixOut      <= inDark ? pixIn : corrected;
    end
  end

  sequence s_dark_end;
    endOfDark && !frameStart;
  endsequence

  sequence s_image_pix;
    inImage && pixInValid && !frameStart;
  endsequence

  sequence s_cal_update;
    darkDone_reg && autoEn && !frozen;
  endsequence

  a_dark_raw: assert property (@(posedge clk) disable iff (!nrst)
    (inDark && pixInValid) |=> (pixOut == $past(pixIn)) && pixOutDark)
    else $error("dark sample was altered");

  a_skip_blank: assert property (@(posedge clk) disable iff (!nrst)
    (inDark && blankLine) |=> !pixOutValid)
    else $error("first dark line not blanked");

  a_dark_to_image: assert property (@(posedge clk) disable iff (!nrst)
    s_dark_end |=> inImage && (lineCnt_reg == linesLatched_reg))
    else $error("dark phase did not end after the programmed lines");

  a_line_bound: assert property (@(posedge clk) disable iff (!nrst)
    (inDark && $past(frameStart) && !$past(rollingShutter)) |-> (lineLenPix_reg == 13'h0510))
    else $error("global shutter dark line length wrong");

  a_manual_add: assert property (@(posedge clk) disable iff (!nrst)
    (s_image_pix and (!autoEn && !ctrl_reg[`OFS_SIGN_BIT])) |=> (pixOut >= $past(pixIn)))
    else $error("manual positive offset lowered pixel");

  a_manual_sub: assert property (@(posedge clk) disable iff (!nrst)
    (s_image_pix and (!autoEn && ctrl_reg[`OFS_SIGN_BIT])) |=> (pixOut <= $past(pixIn)))
    else $error("manual negative offset raised pixel");

  a_sat_top: assert property (@(posedge clk) disable iff (!nrst)
    (s_image_pix and (pixIn == `PIX_MAX) and (appliedOfs >= 11'sh000)) |=> (pixOut == `PIX_MAX))
    else $error("pixel wrapped at full scale");

  a_freeze_hold: assert property (@(posedge clk) disable iff (!nrst)
    (frozen && $past(frozen)) |-> $stable(offs_reg[0]) && $stable(insufficientSampleFlags))
    else $error("frozen factors changed");

  a_recompute: assert property (@(posedge clk) disable iff (!nrst)
    (s_cal_update and colEnough[0])
      |=> (offs_reg[0] == offset_t'($signed({1'b0, `BLACK_TARGET})
                                    - $signed({1'b0, $past(colMean[0])}))))
    else $error("factor not recomputed at dark end");

  a_err_flags: assert property (@(posedge clk) disable iff (!nrst)
    s_cal_update |=> (insufficientSampleFlags == ~$past(colEnough)))
    else $error("shortage flags wrong");
endmodule : black_level_calibration

/* hdl/black_level_calibration_map.svh */
// register offsets, field positions, reset values and fixed counts of the black level block
// assumes 9-bit register addresses and 16-bit register words
`ifndef BLACK_LEVEL_CALIBRATION_MAP_SVH
`define BLACK_LEVEL_CALIBRATION_MAP_SVH

`define FILTER_CFG_ADDR   9'h080
`define BLACK_CAL_CTRL_ADDR 9'h081
`define SAMPLE_ERR_ADDR   9'h088
`define DARK_LINE_CFG_ADDR 9'h0c5

`define AUTO_EN_BIT       0
`define OFS_LSB           1
`define OFS_MSB           9
`define OFS_SIGN_BIT      10
`define LINES_LSB         0
`define LINES_MSB         7
`define SKIP_FIRST_BIT    8
`define EXP_LSB           8
`define EXP_MSB           10

`define CTRL_RESET        16'h0001
`define DARK_CFG_RESET    16'h0001
`define FILTER_CFG_RESET  16'h0300

`define OFS_FREEZE        9'h01ff
`define GS_LINE_KERNELS   10'h0a2
`define KERNEL_COLS       8
`define BLACK_TARGET      10'h0000
`define PIX_MAX           10'h03ff

`endif

/* hdl/black_level_calibration_pkg.sv */
// types shared by the black level calibration files
// assumes the map header supplies all numeric constants
package black_level_calibration_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DARK  = 3'b010,
    ST_IMAGE = 3'b100
  } blc_state_e;
  typedef logic [9:0]         pixel_t;
  typedef logic signed [10:0] offset_t;
endpackage : black_level_calibration_pkg

/* hdl/blc_col_accum.sv */
// one kernel column's dark sample accumulator: sums the first 2^exp samples
// assumes clear is pulsed at frame start, before any sample of that frame
`timescale 1ns/10ps
module blc_col_accum
  import black_level_calibration_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // control
  input  wire logic         clear,
  input  wire logic         sampleEn,
  input  wire logic [2:0]   expSel,
  input  wire pixel_t       sample,
  // result
  output pixel_t            mean,
  output logic              enough
);
  logic [16:0] sum_reg;
  logic [7:0]  count_reg;
  logic [7:0]  wanted;

  assign wanted = 8'h01 << expSel;
  assign enough = (count_reg == wanted);
  assign mean   = 10'(sum_reg >> expSel);

  // samples beyond the requested count are dropped, so the mean is an exact average
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sum_reg   <= 17'h0_0000;
      count_reg <= 8'h00;
    end else if (clear) begin
      sum_reg   <= 17'h0_0000;
      count_reg <= 8'h00;
    end else if (sampleEn && !enough) begin
      sum_reg   <= sum_reg + {7'h00, sample};
      count_reg <= count_reg + 8'h01;
    end
  end
endmodule : blc_col_accum

/* test/blc_receiver.sv */
// receiver model on the corrected pixel stream: counts the valid raw dark samples of a frame
// assumes darkPhase rises once per frame, at the start of the dark lines
`timescale 1ns/10ps
module blc_receiver (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // stream from the block
  input  wire logic         pixValid,
  input  wire logic         pixDark,
  input  wire logic         darkPhase,
  // statistics
  output logic [15:0]       darkCount
);
  logic phaseSeen_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) phaseSeen_reg <= 1'b0;
    else phaseSeen_reg <= darkPhase;
  end

  // count restarts on the frame's dark phase so a blanked line never leaks in from before
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) darkCount <= 16'h0000;
    else if (darkPhase && !phaseSeen_reg) darkCount <= {15'h0000, pixValid && pixDark};
    else if (pixValid && pixDark) darkCount <= darkCount + 16'h0001;
  end
endmodule : blc_receiver

/* test/black_level_calibration_test.sv */
// self-checking bench of the black level block: registers, dark lines, manual and auto offset
// assumes the block answers each pixel one cycle later and registers act from the next cycle
`timescale 1ns/10ps
`include "black_level_calibration_map.svh"
module black_level_calibration_test;
  import black_level_calibration_pkg::*;
  logic clk, nrst, regWrEn, regRdEn, rollingShutter, frameStart, pixInValid;
  logic pixOutValid, pixOutDark, darkPhase;
  logic [8:0]  regAddr;
  logic [15:0] regWrData, regRdData, darkCount;
  logic [9:0]  activeLineKernels;
  logic [7:0]  insufficientSampleFlags;
  pixel_t      pixIn, pixOut;
  int          fail_count = 0;
  int          check_count = 0;

  black_level_calibration dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .rollingShutter(rollingShutter), .activeLineKernels(activeLineKernels),
    .frameStart(frameStart), .pixIn(pixIn), .pixInValid(pixInValid), .pixOut(pixOut),
    .pixOutValid(pixOutValid), .pixOutDark(pixOutDark), .darkPhase(darkPhase),
    .insufficientSampleFlags(insufficientSampleFlags));
  blc_receiver rx (.clk(clk), .nrst(nrst), .pixValid(pixOutValid), .pixDark(pixOutDark),
    .darkPhase(darkPhase), .darkCount(darkCount));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    regAddr = a; regWrData = d; regWrEn = 1'b1;
    @(posedge clk); #1;
    regWrEn = 1'b0;
    // idle edge so a following call never raises the strobe in the step that lowered it
    @(posedge clk); #1;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    regAddr = a; regRdEn = 1'b1;
    @(posedge clk); #1;
    regRdEn = 1'b0;
    check("regRdData", e, regRdData);
    @(posedge clk); #1;
  endtask : rd

  // drives one pixel and judges the answer that lands one cycle later
  task automatic sendPix(input pixel_t v, input logic ev, input pixel_t eo, input logic ed);
    pixIn = v; pixInValid = 1'b1;
    @(posedge clk); #1;
    check("pixOutValid", {15'h0000, ev}, {15'h0000, pixOutValid});
    if (ev) check("pixOut", {6'h00, eo}, {6'h00, pixOut});
    if (ev) check("pixOutDark", {15'h0000, ed}, {15'h0000, pixOutDark});
  endtask : sendPix

  // one frame's dark lines, value base plus column, then the dark sample count
  task automatic darkFrame(input int lines, input bit skip, input bit rs, input int k,
                           input pixel_t base);
    int len, n;
    len = rs ? k * 8 : 1296;
    n = 0;
    wr(`DARK_LINE_CFG_ADDR, {7'h00, skip, lines[7:0]});
    rollingShutter = rs; activeLineKernels = k[9:0];
    frameStart = 1'b1;
    pixInValid = 1'b0;
    @(posedge clk); #1;
    frameStart = 1'b0;
    for (int l = 0; l < lines; l++) begin
      for (int p = 0; p < len; p++) begin
        sendPix(base + pixel_t'(p % 8), !(skip && l == 0), base + pixel_t'(p % 8), 1'b1);
        if (!(skip && l == 0)) n++;
      end
    end
    pixInValid = 1'b0;
    @(posedge clk); #1;
    check("darkCount", n[15:0], darkCount);
  endtask : darkFrame

  task automatic regTest;
    rd(`BLACK_CAL_CTRL_ADDR, `CTRL_RESET);
    rd(`DARK_LINE_CFG_ADDR, `DARK_CFG_RESET);
    rd(`FILTER_CFG_ADDR, `FILTER_CFG_RESET);
    wr(9'h1ff, 16'h5a5a);
    rd(9'h1ff, 16'h0000);
    wr(`SAMPLE_ERR_ADDR, 16'h00ff);
    rd(`SAMPLE_ERR_ADDR, 16'h0000);
  endtask : regTest

  task automatic lineTest;
    darkFrame(3, 1'b0, 1'b1, 2, 10'h010);
    darkFrame(2, 1'b1, 1'b1, 1, 10'h020);
    darkFrame(1, 1'b0, 1'b0, 2, 10'h030);
    darkFrame(255, 1'b0, 1'b1, 1, 10'h040);
  endtask : lineTest

  task automatic manualTest;
    wr(`BLACK_CAL_CTRL_ADDR, 16'h000a);
    darkFrame(1, 1'b0, 1'b1, 1, 10'h007);
    for (int c = 0; c < 8; c++) sendPix(10'd100 + c[9:0], 1'b1, 10'd105 + c[9:0], 1'b0);
    sendPix(10'd1020, 1'b1, 10'd1023, 1'b0);
    wr(`BLACK_CAL_CTRL_ADDR, 16'h040a);
    darkFrame(1, 1'b0, 1'b1, 1, 10'h007);
    sendPix(10'd100, 1'b1, 10'd95, 1'b0);
    sendPix(10'd3, 1'b1, 10'd0, 1'b0);
  endtask : manualTest

  // image pixel c of 100 must come out as 100 minus the column's dark level
  task automatic autoImage(input pixel_t lvl);
    for (int c = 0; c < 8; c++) sendPix(10'd100, 1'b1, 10'd100 - lvl - c[9:0], 1'b0);
  endtask : autoImage

  task automatic autoTest;
    wr(`FILTER_CFG_ADDR, 16'h0000);
    wr(`BLACK_CAL_CTRL_ADDR, 16'h0401);
    darkFrame(1, 1'b0, 1'b1, 1, 10'd10);
    autoImage(10'd10);
    check("insufficientSampleFlags", 16'h0000, {8'h00, insufficientSampleFlags});
    darkFrame(1, 1'b0, 1'b1, 1, 10'd20);
    autoImage(10'd20);
    wr(`BLACK_CAL_CTRL_ADDR, 16'h03ff);
    darkFrame(1, 1'b0, 1'b1, 1, 10'd50);
    autoImage(10'd20);
    wr(`FILTER_CFG_ADDR, 16'h0300);
    wr(`BLACK_CAL_CTRL_ADDR, 16'h0001);
    darkFrame(1, 1'b0, 1'b1, 1, 10'd30);
    autoImage(10'd20);
    check("insufficientSampleFlags", 16'h00ff, {8'h00, insufficientSampleFlags});
    rd(`SAMPLE_ERR_ADDR, 16'h00ff);
  endtask : autoTest

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim;
  end

  initial begin
    nrst = 1'b0; regAddr = 9'h000; regWrData = 16'h0000; regWrEn = 1'b0; regRdEn = 1'b0;
    rollingShutter = 1'b1; activeLineKernels = 10'h001; frameStart = 1'b0;
    pixIn = 10'h000; pixInValid = 1'b0;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk); #1;
    regTest;
    lineTest;
    manualTest;
    autoTest;
    end_sim;
  end
endmodule : black_level_calibration_test
